// ==== srrd_pkg.sv ====
// package for the system rom region decoder
package srrd_pkg;
    // configuration access
    localparam logic [7:0] SRRD_CFG_DATA_PORT = 8'hED;
    localparam logic [7:0] SRRD_ROM_CONTROL_IDX = 8'h0C;
    // rom_control field positions
    localparam int SRRD_BIT_WIDTH = 7;
    localparam int SRRD_BIT_MOV2 = 6;
    localparam int SRRD_BIT_MOV1 = 5;
    localparam int SRRD_BIT_MOV0 = 4;
    localparam int SRRD_BIT_MIDDLE_BIOS_DISABLE = 3;
    localparam int SRRD_BIT_FLASH = 2;
    localparam int SRRD_BIT_WS1 = 1;
    localparam int SRRD_BIT_WS0 = 0;
    localparam logic [5:0] SRRD_CTRL_LOW_RESET = 6'h00;
    // address ranges, 20-bit segment bases compared on a19..a15 (video, disk) or a19..a16 (e, f); middle bios tag on a23..a17
    localparam logic [4:0] SRRD_SEG_VIDEO = 5'h18;
    localparam logic [4:0] SRRD_SEG_DISK = 5'h19;
    localparam logic [3:0] SRRD_SEG_E = 4'hE;
    localparam logic [3:0] SRRD_SEG_F = 4'hF;
    localparam logic [14:0] SRRD_MID_BIOS_TAG = 15'h007F;
    // rom wait-state table
    localparam logic [1:0] SRRD_WS_00 = 2'h3;
    localparam logic [1:0] SRRD_WS_01 = 2'h1;
    localparam logic [1:0] SRRD_WS_10 = 2'h2;
    localparam logic [1:0] SRRD_WS_11 = 2'h3;
    // routing of a decoded access
    typedef enum logic [3:0] {
        SRRD_RT_NONE = 4'h1,
        SRRD_RT_DBUS = 4'h2,
        SRRD_RT_SDBUS = 4'h4,
        SRRD_RT_SLOT = 4'h8
    } srrd_route_type;
    // decoded access answer
    typedef struct packed {
        srrd_route_type route;
        logic           rom_chip_select_n;
        logic [1:0]     wait_states;
        logic [1:0]     rom_addr_lo;
        logic           rom_wide;
        logic [3:0]     lane_enable;
    } srrd_answer_type;
endpackage : srrd_pkg

// ==== srrd_decoder.sv ====
// system rom region decoder with rom control register
`timescale 1ns/1ns
`default_nettype none
// How it works
// - bit 6 puts all system rom on d bus or sd bus; f segment always rom unless remap hits
// - mov low bits select e segment, video and fixed-disk ranges as rom
// - rom chip select asserts for every access in a rom-decoded range
// - slot ranges run isa cycles, no chip select, isa bus control waits
// - rom waits from two-bit field: 3,1,2,3
// - segment control or memory region remap overrides rom decode
// - flash enable drives programming output low, enables special addressing
// - local-bus flash occupies d23-d16 for 8-bit, d31-d16 for 16-bit
// - flash mode on d bus turns cpu byte 2 write into rom byte 3
// - sd-bus flash writes are plain isa writes with normal address bits
// - middle bios range is rom unless disable bit is set
// - rom control read/write at index 0ch via data port edh
// - power-up loads width and placement from straps, rest cleared
// - 8-bit local rom assembles several cycles for wide cpu reads
module srrd_decoder
    import srrd_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // straps
    input  wire logic        size_strap_pin,
    input  wire logic        dram_write_strap_n,
    // configuration port
    input  wire logic        cfg_write,
    input  wire logic        cfg_read,
    input  wire logic [7:0]  cfg_index,
    input  wire logic [7:0]  cfg_wdata,
    output logic      [7:0]  cfg_rdata,
    // cpu access
    input  wire logic        cpu_access,
    input  wire logic        cpu_write,
    input  wire logic [23:2] cpu_addr,
    input  wire logic [3:0]  cpu_byte_en_n,
    input  wire logic        remap_hit,
    input  wire logic [1:0]  isa_bus_control,
    input  wire logic [7:0]  rom_lane_data,
    // decode outputs
    output srrd_answer_type  answer,
    output logic             answer_valid,
    output logic             flash_program_n,
    output logic [31:0]      rom_read_data,
    output logic             rom_read_done
);
    logic [7:0] rom_control;
    logic [7:0] next_rom_control;
    logic       strap_pending;
    logic       next_strap_pending;
    srrd_answer_type next_answer;
    logic       next_answer_valid;
    logic [31:0] next_rom_read_data;
    logic [2:0] asm_count;
    logic [2:0] next_asm_count;
    logic       next_rom_read_done;
    logic [3:0] byte_en;
    logic [2:0] mov;
    logic       in_f;
    logic       in_e;
    logic       in_video;
    logic       in_disk;
    logic       in_mid;
    logic       is_rom;

    assign byte_en = ~cpu_byte_en_n;
    assign mov = rom_control[SRRD_BIT_MOV2:SRRD_BIT_MOV0];
    assign in_f = cpu_addr[23:20] == 4'h0 && cpu_addr[19:16] == SRRD_SEG_F;
    assign in_e = cpu_addr[23:20] == 4'h0 && cpu_addr[19:16] == SRRD_SEG_E;
    assign in_video = cpu_addr[23:20] == 4'h0 && cpu_addr[19:15] == SRRD_SEG_VIDEO;
    assign in_disk = cpu_addr[23:20] == 4'h0 && cpu_addr[19:15] == SRRD_SEG_DISK;
    assign in_mid = cpu_addr[23:17] == SRRD_MID_BIOS_TAG[6:0];

    // rom decode
    always_comb begin
        is_rom = 1'b0;
        if (in_f) begin
            is_rom = 1'b1;
        end
        if (in_e && mov[1:0] == 2'h0) begin
            is_rom = 1'b1;
        end
        if (in_video && mov[1]) begin
            is_rom = 1'b1;
        end
        if (in_disk && mov[1:0] == 2'h3) begin
            is_rom = 1'b1;
        end
        if (in_mid && !rom_control[SRRD_BIT_MIDDLE_BIOS_DISABLE]) begin
            is_rom = 1'b1;
        end
        if (remap_hit) begin
            is_rom = 1'b0;
        end
    end

    // register and strap capture
    always_comb begin
        next_rom_control = rom_control;
        next_strap_pending = 1'b0;
        if (strap_pending) begin
            next_rom_control[SRRD_BIT_WIDTH] = size_strap_pin;
            next_rom_control[SRRD_BIT_MOV2] = dram_write_strap_n;
        end else if (cfg_write && cfg_index == SRRD_ROM_CONTROL_IDX) begin
            next_rom_control = cfg_wdata;
        end
        cfg_rdata = 8'h00;
        if (cfg_read && cfg_index == SRRD_ROM_CONTROL_IDX) begin
            cfg_rdata = rom_control;
        end
    end

    // per-access answer
    always_comb begin
        next_answer = answer;
        next_answer_valid = 1'b0;
        if (cpu_access) begin
            next_answer_valid = 1'b1;
            next_answer.rom_wide = rom_control[SRRD_BIT_WIDTH];
            next_answer.rom_addr_lo = 2'h0;
            for (int i = 3; i >= 0; i--) begin
                if (byte_en[i]) begin
                    next_answer.rom_addr_lo = 2'(i);
                end
            end
            if (is_rom) begin
                next_answer.route = mov[2] ? SRRD_RT_SDBUS : SRRD_RT_DBUS;
                next_answer.rom_chip_select_n = 1'b0;
                case (rom_control[SRRD_BIT_WS1:SRRD_BIT_WS0])
                    2'h0: next_answer.wait_states = SRRD_WS_00;
                    2'h1: next_answer.wait_states = SRRD_WS_01;
                    2'h2: next_answer.wait_states = SRRD_WS_10;
                    default: next_answer.wait_states = SRRD_WS_11;
                endcase
                if (!mov[2]) begin
                    next_answer.lane_enable = rom_control[SRRD_BIT_WIDTH] ? 4'hC : 4'h4;
                end else begin
                    next_answer.lane_enable = byte_en;
                end
                if (rom_control[SRRD_BIT_FLASH] && !mov[2] && cpu_write
                        && byte_en == 4'h4) begin
                    next_answer.rom_addr_lo = 2'h3;
                end
            end else begin
                next_answer.route = SRRD_RT_SLOT;
                next_answer.rom_chip_select_n = 1'b1;
                next_answer.wait_states = isa_bus_control;
                next_answer.lane_enable = byte_en;
            end
        end
    end

    // 8-bit local rom read assembly
    always_comb begin
        next_rom_read_data = rom_read_data;
        next_asm_count = asm_count;
        next_rom_read_done = 1'b0;
        if (cpu_access && is_rom && !cpu_write && !mov[2]
                && !rom_control[SRRD_BIT_WIDTH]) begin
            next_rom_read_data = 32'h0;
            next_asm_count = 3'h0;
        end else if (answer_valid && answer.route == SRRD_RT_DBUS && !cpu_write
                && !answer.rom_wide || asm_count != 3'h4) begin
            if (asm_count < 3'h4) begin
                next_rom_read_data[8 * asm_count +: 8] = rom_lane_data;
                next_asm_count = asm_count + 3'h1;
                next_rom_read_done = asm_count == 3'h3;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rom_control <= {2'h0, SRRD_CTRL_LOW_RESET};
            strap_pending <= 1'b1;
            answer <= '{SRRD_RT_NONE, 1'b1, 2'h0, 2'h0, 1'b0, 4'h0};
            answer_valid <= 1'b0;
            rom_read_data <= 32'h0;
            asm_count <= 3'h4;
            rom_read_done <= 1'b0;
        end else if (clk_en) begin
            rom_control <= next_rom_control;
            strap_pending <= next_strap_pending;
            answer <= next_answer;
            answer_valid <= next_answer_valid;
            rom_read_data <= next_rom_read_data;
            asm_count <= next_asm_count;
            rom_read_done <= next_rom_read_done;
        end
    end

    assign flash_program_n = ~rom_control[SRRD_BIT_FLASH];

    // checks
    chip_select_route_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        answer_valid |-> (answer.rom_chip_select_n == (answer.route == SRRD_RT_SLOT)))
        else $error("chip select disagrees with route");
    f_segment_rom_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && cpu_access && in_f && !remap_hit |=> !answer.rom_chip_select_n)
        else $error("f segment not rom");
    remap_wins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && cpu_access && remap_hit |=> answer.route == SRRD_RT_SLOT)
        else $error("remap did not override");
    flash_on_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && !strap_pending && cfg_write && cfg_index == SRRD_ROM_CONTROL_IDX
        && cfg_wdata[SRRD_BIT_FLASH] |=> !flash_program_n)
        else $error("flash output not driven low");
    flash_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && !strap_pending && cfg_write && cfg_index == SRRD_ROM_CONTROL_IDX
        && !cfg_wdata[SRRD_BIT_FLASH] |=> flash_program_n)
        else $error("flash output not released");
    rom_waits_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && cpu_access && is_rom && rom_control[1:0] == 2'h1
        |=> answer.wait_states == 2'h1)
        else $error("rom waits wrong");
    slot_waits_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && cpu_access && !is_rom |=> answer.wait_states == $past(isa_bus_control))
        else $error("slot waits wrong");
    mid_bios_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && cpu_access && in_mid && rom_control[SRRD_BIT_MIDDLE_BIOS_DISABLE]
        |=> answer.rom_chip_select_n)
        else $error("middle bios not switched out");
    cfg_readback_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && !strap_pending && cfg_write && cfg_index == SRRD_ROM_CONTROL_IDX
        |=> rom_control == $past(cfg_wdata))
        else $error("register write lost");
    // assembly start, then four quiet enabled cycles
    sequence asm_start_s;
        clk_en && cpu_access && is_rom && !cpu_write && !mov[2] && !rom_control[SRRD_BIT_WIDTH];
    endsequence
    sequence asm_quiet_s;
        (clk_en && !cpu_access) [*4];
    endsequence
    read_assembly_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        asm_start_s ##1 asm_quiet_s |=> rom_read_done)
        else $error("rom read not assembled");
endmodule : srrd_decoder
`default_nettype wire

// ==== srrd_cpu_model.sv ====
// cpu bus master and rom byte source facing the decoder
`timescale 1ns/1ns
`default_nettype none
module srrd_cpu_model (
    // clock
    input  wire logic        sys_clk,
    // cpu access
    output logic             cpu_access,
    output logic             cpu_write,
    output logic      [23:2] cpu_addr,
    output logic      [3:0]  cpu_byte_en_n,
    // rom bytes on d23-d16
    output logic      [7:0]  rom_lane_data
);
    int k;
    initial begin
        cpu_access = 1'b0;
        cpu_write = 1'b0;
        cpu_addr = '0;
        cpu_byte_en_n = 4'hF;
        rom_lane_data = 8'h00;
        k = 0;
    end
    // one access pulse; address, byte enables and write flag come from the caller
    task automatic access(input logic [23:0] a, input logic [3:0] be_n, input logic wr);
        @(posedge sys_clk);
        #1;
        cpu_access = 1'b1;
        cpu_write = wr;
        cpu_addr = a[23:2];
        cpu_byte_en_n = be_n;
        @(posedge sys_clk);
        #1;
        cpu_access = 1'b0;
        cpu_addr = ~cpu_addr;
    endtask : access
    // bytes 11,22,33,44 one per cycle from the access edge, then a changing pattern
    always @(posedge sys_clk) begin
        k = cpu_access ? 1 : (k > 0 && k < 4) ? k + 1 : 0;
        #1;
        rom_lane_data = (k > 0) ? 8'(k * 8'h11) : ~rom_lane_data;
    end
endmodule : srrd_cpu_model
`default_nettype wire

// ==== srrd_decoder_bench.sv ====
// self-checking testbench for the system rom region decoder
`timescale 1ns/1ns
`default_nettype none
module srrd_decoder_bench;
    import srrd_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic cfg_write = 1'b0;
    logic cfg_read = 1'b0;
    logic [7:0] cfg_index = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata;
    logic cpu_access, cpu_write, remap_hit = 1'b0;
    logic [23:2] cpu_addr;
    logic [3:0] cpu_byte_en_n;
    logic [1:0] isa = 2'h2;
    logic clk_en = 1'b1;
    logic [7:0] lane;
    srrd_answer_type answer;
    logic answer_valid, flash_program_n, rom_read_done;
    logic [31:0] rom_read_data;
    int miscompares = 0;
    int samples_checked = 0;
    logic [23:0] base [5] = '{24'hF0000, 24'hE0000, 24'hE8000, 24'hC0000, 24'hC8000};
    logic rom;
    always #10 sys_clk = ~sys_clk;
    srrd_decoder u_dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .size_strap_pin(1'b1), .dram_write_strap_n(1'b0), .cfg_write(cfg_write),
        .cfg_read(cfg_read), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cpu_access(cpu_access), .cpu_write(cpu_write),
        .cpu_addr(cpu_addr), .cpu_byte_en_n(cpu_byte_en_n), .remap_hit(remap_hit),
        .isa_bus_control(isa), .rom_lane_data(lane), .answer(answer),
        .answer_valid(answer_valid), .flash_program_n(flash_program_n),
        .rom_read_data(rom_read_data), .rom_read_done(rom_read_done));
    srrd_cpu_model u_cpu (.sys_clk(sys_clk),
        .cpu_access(cpu_access), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
        .cpu_byte_en_n(cpu_byte_en_n), .rom_lane_data(lane));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        cfg_write = 1'b1;
        cfg_index = i;
        cfg_wdata = d;
        @(posedge sys_clk);
        #1;
        cfg_write = 1'b0;
    endtask : cfg_wr
    task automatic cfg_rd(input logic [7:0] i, input logic [7:0] e);
        @(posedge sys_clk);
        #1;
        cfg_read = 1'b1;
        cfg_index = i;
        @(negedge sys_clk);
        chk("cfg_rdata", 32'(e), 32'(cfg_rdata));
        @(posedge sys_clk);
        #1;
        cfg_read = 1'b0;
    endtask : cfg_rd
    task automatic go(input logic [23:0] a, input logic [3:0] be, input logic wr);
        u_cpu.access(a, be, wr);
        chk("answer_valid", 32'h1, 32'(answer_valid));
    endtask : go
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        repeat (2) @(posedge sys_clk);
        cfg_rd(SRRD_ROM_CONTROL_IDX, 8'h80);
        chk("flash_program_n", 32'h1, 32'(flash_program_n));
        cfg_wr(8'h0D, 8'h55);
        cfg_rd(8'h0D, 8'h00);
        clk_en = 1'b0;
        cfg_wr(SRRD_ROM_CONTROL_IDX, 8'h55);
        clk_en = 1'b1;
        cfg_rd(SRRD_ROM_CONTROL_IDX, 8'h80);
        for (int m = 0; m < 8; m++) begin
            cfg_wr(SRRD_ROM_CONTROL_IDX, {1'b1, 3'(m), 2'h0, 2'(m)});
            cfg_rd(SRRD_ROM_CONTROL_IDX, {1'b1, 3'(m), 2'h0, 2'(m)});
            isa = 2'(m + 1);
            for (int r = 0; r < 5; r++) begin
                go(base[r], 4'h0, 1'b0);
                rom = r == 0 || (r < 3 && m[1:0] == 0) || (r == 3 && m[1])
                    || (r == 4 && m[1:0] == 3);
                chk("cs_n", 32'(!rom), 32'(answer.rom_chip_select_n));
                chk("route", rom ? (m[2] ? 32'h4 : 32'h2) : 32'h8, 32'(answer.route));
                chk("waits", rom ? (m[1:0] == 0 ? 32'h3 : 32'(m[1:0])) : 32'(isa),
                    32'(answer.wait_states));
            end
        end
        remap_hit = 1'b1;
        go(24'hF0000, 4'h0, 1'b0);
        chk("remap cs_n", 32'h1, 32'(answer.rom_chip_select_n));
        remap_hit = 1'b0;
        cfg_wr(SRRD_ROM_CONTROL_IDX, 8'h04);
        chk("flash_program_n", 32'h0, 32'(flash_program_n));
        go(24'hF0000, 4'hB, 1'b1);
        chk("addr_lo", 32'h3, 32'(answer.rom_addr_lo));
        chk("lanes8", 32'h4, 32'(answer.lane_enable));
        chk("cs_n", 32'h0, 32'(answer.rom_chip_select_n));
        go(24'hF0001, 4'h9, 1'b1);
        chk("addr_lo", 32'h1, 32'(answer.rom_addr_lo));
        go(24'hF0002, 4'h3, 1'b1);
        chk("addr_lo", 32'h2, 32'(answer.rom_addr_lo));
        cfg_wr(SRRD_ROM_CONTROL_IDX, 8'h84);
        go(24'hF0000, 4'h0, 1'b1);
        chk("lanes16", 32'hC, 32'(answer.lane_enable));
        chk("wide", 32'h1, 32'(answer.rom_wide));
        go(24'hF0002, 4'h3, 1'b1);
        chk("addr_lo", 32'h2, 32'(answer.rom_addr_lo));
        cfg_wr(SRRD_ROM_CONTROL_IDX, 8'h80);
        chk("flash_program_n", 32'h1, 32'(flash_program_n));
        go(24'hF0000, 4'hB, 1'b1);
        chk("addr_lo", 32'h2, 32'(answer.rom_addr_lo));
        cfg_wr(SRRD_ROM_CONTROL_IDX, 8'hC4);
        go(24'hF0000, 4'hB, 1'b1);
        chk("sd addr_lo", 32'h2, 32'(answer.rom_addr_lo));
        chk("sd cs_n", 32'h0, 32'(answer.rom_chip_select_n));
        cfg_wr(SRRD_ROM_CONTROL_IDX, 8'h80);
        go(24'hFE0000, 4'h0, 1'b0);
        chk("mid cs_n", 32'h0, 32'(answer.rom_chip_select_n));
        cfg_wr(SRRD_ROM_CONTROL_IDX, 8'h88);
        go(24'hFE0000, 4'h0, 1'b0);
        chk("mid off cs_n", 32'h1, 32'(answer.rom_chip_select_n));
        cfg_wr(SRRD_ROM_CONTROL_IDX, 8'h00);
        go(24'hF0000, 4'h0, 1'b0);
        chk("wide", 32'h0, 32'(answer.rom_wide));
        for (int w = 0; w < 20 && rom_read_done !== 1'b1; w++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("rom_read_done", 32'h1, 32'(rom_read_done));
        chk("rom_read_data", 32'h44332211, rom_read_data);
        repeat (2) @(posedge sys_clk);
        test_done();
    end
endmodule : srrd_decoder_bench
`default_nettype wire
